/* hw/dtb_fifo.sv */
// Parameterised valid/ready FIFO built from flip-flops.
`timescale 1ns/100ps
module dtb_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  // Refuses depths that the wrap-bit pointers cannot serve.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("FIFO depth must be a power of two");
  end
  // Storage and pointers with one extra wrap bit.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  // Pointer update; flush drops all queued lines.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + (AW+1)'(1);
      if (pop) rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
  // Data storage has no reset.
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
endmodule

/* hw/dtb_pkg.sv */
// Package with constants and carrier types of the debug trace buffer store.
package dtb_pkg;
  // Trace store geometry.
  localparam int DEPTH = 64;
  localparam int LINE_W = 20;
  localparam int ADDR_W = 18;
  localparam int FIFO_DEPTH = 16;
  // Bit position where the compressed upper address starts (64-byte block).
  localparam int BLK_LSB = 6;
  // Reset value of the line counter.
  localparam logic [6:0] CNT_RST = 7'h00;
  // Size and direction flag encodings.
  localparam logic SZ_WORD = 1'b0;
  localparam logic SZ_BYTE = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // Compressed mode information codes.
  localparam logic [1:0] INF_BASE = 2'h0;
  localparam logic [1:0] INF_ONE = 2'h1;
  localparam logic [1:0] INF_TWO = 2'h2;
  localparam logic [1:0] INF_THREE = 2'h3;

  // Trace modes selected by trace_mode_select.
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_LOOP1 = 2'h1,
    MODE_DETAIL = 2'h2,
    MODE_COMPRESSED = 2'h3
  } dtb_mode_type;

  // Kinds of change of flow reported by the core at instruction completion.
  typedef enum logic [2:0] {
    COF_NONE = 3'h0,
    COF_COND_SRC = 3'h1,
    COF_INDEXED_DST = 3'h2,
    COF_DIRECT = 3'h3,
    COF_RETURN_DST = 3'h4,
    COF_VECTOR = 3'h5,
    COF_DEBUG_VECTOR = 3'h6,
    COF_UNCOND = 3'h7
  } dtb_cof_type;

  // Execute status from the core.
  typedef struct packed {
    logic valid;
    dtb_cof_type kind;
    logic [17:0] addr;
    logic opcode;
  } dtb_exec_type;

  // Bus cycle status from the core.
  typedef struct packed {
    logic valid;
    logic free_cycle;
    logic fetch_cycle;
    logic byte_access;
    logic read;
    logic [17:0] addr;
    logic [15:0] data;
  } dtb_bus_type;

  // Trace control bits.
  typedef struct packed {
    logic trace_source_enable;
    logic trigger_alignment_select;
    dtb_mode_type trace_mode_select;
  } dtb_ctrl_type;
endpackage

/* hw/dtb_store.sv */
// Trace store logic of the debug module: line formatting, alignment and trace RAM.
`timescale 1ns/100ps
// Function
// - Begin alignment: nothing stored before final state
// - Begin alignment: stay armed until 64 lines
// - Begin alignment: store triggering change of flow
// - Tagged begin: trace at tag, break at end
// - End alignment: store until final, then disarm
// - End alignment: triggering change of flow not stored
// - End alignment: pointer wraps, overwrites oldest
// - Four modes, trace only when source enabled
// - Normal: store listed change-of-flow addresses
// - Normal: skip unconditional, direct and background
// - Normal entry: 18-bit address plus info
// - Destination stored at completion despite interrupt
// - Loop1: shadow register, drop repeated source
// - Loop1: keep repeated destinations and vectors
// - Detail: all accesses except free and fetch
// - Detail: size and direction info bits
// - Compressed: every opcode, full address per block
// - Compressed row: 2 info bits, 18 address
// - Detail: two lines per entry, count twice
// - Detail: byte low, word lower-address byte high
// - Shared line format; data line top field zero
// - Forced break latency may store extra opcodes
// - 64 by 20 circular RAM, counter advances
// - Size 0 word 1 byte; dir 0 write
// - Compressed codes 00 base, 01-11 increments
module dtb_store
  import dtb_pkg::*;
#(
  parameter int FIFO_W = LINE_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dtb_ctrl_type ctrl_i,
  input wire logic arm_i,
  input wire logic final_i,
  input wire logic tagged_i,
  input wire dtb_exec_type exec_i,
  input wire dtb_bus_type bus_i,
  input wire logic [5:0] rd_index_i,
  output logic [LINE_W-1:0] rd_line_o,
  output logic [6:0] trace_line_counter_o,
  output logic armed_o,
  output logic session_done_o,
  output logic break_req_o,
  output logic stall_o
);
  // Refuses a FIFO that cannot carry whole lines or absorb a burst.
  if (FIFO_W != LINE_W || FIFO_D < 4) begin
    $error("FIFO must be line wide and at least 4 deep");
  end

  // Session states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_POST,
    ST_DONE
  } dtb_state_type;
  dtb_state_type state;
  dtb_state_type next_state;

  // Trace RAM, write pointer and stored-line count.
  logic [LINE_W-1:0] ram [DEPTH];
  logic [5:0] wr_ptr;
  logic [6:0] count;
  // Lines written since the trigger in begin alignment.
  logic [6:0] post_count;
  // Loop1 shadow of the last stored address and its source flag.
  logic [17:0] shadow_addr;
  logic shadow_src;
  // Compressed mode base block and pending increments.
  logic [11:0] base_blk;
  logic base_valid;
  logic [1:0] pend_n;
  logic [17:0] pend;
  // Pending data line of a detail entry.
  logic data_pend;
  logic [LINE_W-1:0] data_line;
  // Compressed base line queued behind a flushed increment line.
  logic base_pend;
  logic [LINE_W-1:0] base_line;

  // Decoding of the control and status inputs.
  wire begin_al = ctrl_i.trigger_alignment_select;
  wire enabled = ctrl_i.trace_source_enable && arm_i;
  wire capturing = enabled && ((state == ST_PRE) || (state == ST_POST));
  wire mode_cof = (ctrl_i.trace_mode_select == MODE_NORMAL) ||
                  (ctrl_i.trace_mode_select == MODE_LOOP1);
  wire mode_loop = ctrl_i.trace_mode_select == MODE_LOOP1;
  wire mode_det = ctrl_i.trace_mode_select == MODE_DETAIL;
  wire mode_cmp = ctrl_i.trace_mode_select == MODE_COMPRESSED;

  // Change-of-flow classification: sources, destinations, vectors.
  wire cof_src = exec_i.kind == COF_COND_SRC;
  wire cof_vec = exec_i.kind == COF_VECTOR;
  wire cof_dst = (exec_i.kind == COF_INDEXED_DST) || (exec_i.kind == COF_RETURN_DST) ||
                 cof_vec;
  // Direct, unconditional and debug-vector kinds never qualify.
  wire cof_ok = exec_i.valid && (cof_src || cof_dst);
  // End alignment does not store the event on which the final state is entered.
  wire trig_drop = !begin_al && final_i;
  // Loop1 drops a source equal to the last stored line when that line is a source.
  wire loop_dup = mode_loop && cof_src && shadow_src && (shadow_addr == exec_i.addr);
  wire cof_store = capturing && mode_cof && cof_ok && !trig_drop && !loop_dup;

  // Detail mode: qualify bus cycles, format address and data lines.
  wire det_ok = capturing && mode_det && bus_i.valid && !bus_i.free_cycle &&
                !bus_i.fetch_cycle;
  wire det_size = bus_i.byte_access ? SZ_BYTE : SZ_WORD;
  wire det_dir = bus_i.read ? DIR_READ : DIR_WRITE;
  wire [LINE_W-1:0] det_addr_line = {det_size, det_dir, bus_i.addr};
  // Byte data goes low with the high byte cleared; words keep lower address high.
  wire [15:0] det_data = bus_i.byte_access ? {8'h00, bus_i.data[7:0]} : bus_i.data;
  wire [LINE_W-1:0] det_data_line = {4'h0, det_data};

  // Normal and loop1 line: source/destination, vector, 18-bit address.
  wire [LINE_W-1:0] cof_line = {cof_dst, cof_vec, exec_i.addr};

  // Compressed mode: every executed opcode, base line on block change.
  wire cmp_ok = capturing && mode_cmp && exec_i.valid && exec_i.opcode;
  // The first line after a pointer wrap also carries a base, as does the first line.
  wire cmp_new_base = !base_valid || (exec_i.addr[17:6] != base_blk) ||
                      (wr_ptr == 6'h00 && pend_n == 2'h0);
  wire [LINE_W-1:0] cmp_base_line = {INF_BASE, exec_i.addr};
  wire [LINE_W-1:0] cmp_inc_line = {pend_n, pend};
  wire [5:0] inc = exec_i.addr[5:0];

  // Line request towards the FIFO.
  logic lin_valid;
  logic [LINE_W-1:0] lin_data;
  logic lin_ready;
  logic out_valid;
  logic [LINE_W-1:0] out_data;
  wire flush = !enabled;

  // Selects the line that enters the FIFO this cycle.
  always_comb begin
    lin_valid = 1'b0;
    lin_data = '0;
    if (data_pend) begin
      lin_valid = 1'b1;
      lin_data = data_line;
    end else if (base_pend) begin
      lin_valid = 1'b1;
      lin_data = base_line;
    end else if (cof_store) begin
      lin_valid = 1'b1;
      lin_data = cof_line;
    end else if (det_ok) begin
      lin_valid = 1'b1;
      lin_data = det_addr_line;
    end else if (cmp_ok && cmp_new_base) begin
      lin_valid = 1'b1;
      // Pending increments are flushed first; the base follows next cycle.
      lin_data = (pend_n != 2'h0) ? cmp_inc_line : cmp_base_line;
    end else if (cmp_ok && pend_n == INF_TWO) begin
      lin_valid = 1'b1;
      lin_data = {INF_THREE, inc, pend[11:0]};
    end
  end

  // The core is held while the FIFO cannot take a line or a second line is queued.
  assign stall_o = enabled && (!lin_ready || data_pend || base_pend);

  dtb_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .in_valid_i(lin_valid),
    .in_ready_o(lin_ready),
    .in_data_i(lin_data),
    .out_valid_o(out_valid),
    .out_ready_i(1'b1),
    .out_data_o(out_data)
  );

  // A line leaving the FIFO is written to the RAM this cycle.
  wire ram_we = out_valid && (state != ST_DONE);
  // Begin alignment ends the session after 64 lines following the trigger.
  wire post_full = begin_al && (state == ST_POST) && ram_we &&
                   (post_count == 7'(DEPTH - 1));

  // Session state sequencing.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (enabled) next_state = begin_al ? (final_i ? ST_POST : ST_PRE) : ST_PRE;
      end
      ST_PRE: begin
        if (!enabled) next_state = ST_IDLE;
        else if (final_i && begin_al) next_state = ST_POST;
        else if (final_i) next_state = ST_DONE;
      end
      ST_POST: begin
        if (!enabled) next_state = ST_IDLE;
        else if (post_full) next_state = ST_DONE;
      end
      ST_DONE: begin
        if (!arm_i) next_state = ST_IDLE;
      end
    endcase
  end

  // Begin alignment in the pre state stores nothing; only post lines count.
  wire begin_block = begin_al && (state != ST_POST);

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) state <= ST_IDLE;
    else state <= next_state;
  end

  // RAM pointer and counters; the pointer wraps over the oldest line.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      count <= CNT_RST;
      post_count <= '0;
    end else if (state == ST_IDLE && enabled) begin
      wr_ptr <= '0;
      count <= CNT_RST;
      post_count <= '0;
    end else if (ram_we && !begin_block) begin
      wr_ptr <= wr_ptr + 6'h01;
      if (count != 7'(DEPTH)) count <= count + 7'h01;
      if (state == ST_POST) post_count <= post_count + 7'h01;
    end
  end

  // RAM write port.
  always_ff @(posedge clk_i) begin
    if (ram_we && !begin_block) ram[wr_ptr] <= out_data;
  end

  // Detail data line, issued in the cycle after the address line.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_pend <= 1'b0;
      data_line <= '0;
    end else if (lin_ready) begin
      data_pend <= det_ok && !data_pend && !cof_store;
      data_line <= det_data_line;
    end
  end

  // Loop1 shadow register follows every stored change-of-flow address.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shadow_addr <= '0;
      shadow_src <= 1'b0;
    end else if (flush) begin
      shadow_src <= 1'b0;
    end else if (cof_store && lin_ready && !data_pend) begin
      shadow_addr <= exec_i.addr;
      shadow_src <= cof_src;
    end
  end

  // Compressed mode base and increment packing; the oldest increment sits lowest.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_blk <= '0;
      base_valid <= 1'b0;
      base_pend <= 1'b0;
      base_line <= '0;
      pend_n <= INF_BASE;
      pend <= '0;
    end else if (flush || !mode_cmp) begin
      base_valid <= 1'b0;
      base_pend <= 1'b0;
      pend_n <= INF_BASE;
    end else if (base_pend) begin
      // The queued base line leaves as soon as the FIFO takes it.
      if (lin_ready) base_pend <= 1'b0;
    end else if (cmp_ok && lin_ready && !data_pend && !cof_store && !det_ok) begin
      if (cmp_new_base && pend_n != 2'h0) begin
        // Increments leave now; the new base is queued so no opcode is lost.
        pend_n <= INF_BASE;
        pend <= '0;
        base_blk <= exec_i.addr[17:6];
        base_valid <= 1'b1;
        base_pend <= 1'b1;
        base_line <= cmp_base_line;
      end else if (cmp_new_base) begin
        base_blk <= exec_i.addr[17:6];
        base_valid <= 1'b1;
      end else if (pend_n == INF_TWO) begin
        pend_n <= INF_BASE;
        pend <= '0;
      end else begin
        pend_n <= pend_n + 2'h1;
        // Each new increment goes one field above the older ones.
        pend <= (pend_n == INF_BASE) ? {12'h000, inc} : {6'h00, inc, pend[5:0]};
      end
    end
  end

  // Outputs: readback, counter, session status and breakpoint request.
  assign rd_line_o = ram[rd_index_i];
  assign trace_line_counter_o = count;
  assign armed_o = (state == ST_PRE) || (state == ST_POST);
  assign session_done_o = state == ST_DONE;
  // A tagged begin-aligned session breaks only once storing completes.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) break_req_o <= 1'b0;
    else break_req_o <= (state != ST_DONE) && (next_state == ST_DONE) &&
                        (!begin_al || tagged_i || post_full);
  end
endmodule

/* verif/dtb_core_model.sv */
// Behavioural CPU core that reports executed instructions and bus cycles.
`timescale 1ns/100ps
module dtb_core_model
  import dtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  output dtb_exec_type exec_o,
  output dtb_bus_type bus_o
);
  // Both status channels start idle.
  initial begin
    exec_o = '0;
    bus_o = '0;
  end
  // One completed instruction, held while the store stalls the core.
  task automatic run_op(input dtb_cof_type kind, input logic [17:0] addr);
    @(negedge clk_i);
    exec_o = '{valid: 1'b1, kind: kind, addr: addr, opcode: 1'b1};
    @(posedge clk_i);
    while (stall_i === 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    // An idle channel shows a changed address so stale values never match.
    exec_o.valid = 1'b0;
    exec_o.addr = ~addr;
  endtask
  // One bus cycle; kind is free, fetch, byte and read; a gap keeps entries apart.
  task automatic run_bus(input logic [3:0] kind, input logic [17:0] addr,
    input logic [15:0] data);
    @(negedge clk_i);
    bus_o = {1'b1, kind, addr, data};
    @(posedge clk_i);
    while (stall_i === 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    bus_o.valid = 1'b0;
    bus_o.addr = ~addr;
    bus_o.data = ~data;
  endtask
endmodule

/* verif/dtb_store_properties.sv */
// Concurrent checks on the ports of the trace store.
`timescale 1ns/100ps
module dtb_store_properties
  import dtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dtb_ctrl_type ctrl_i,
  input wire logic final_i,
  input wire logic [6:0] trace_line_counter_o,
  input wire logic armed_o,
  input wire logic session_done_o,
  input wire logic break_req_o
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Short names for the alignment and the counter.
  logic begin_al;
  logic [6:0] cnt;
  assign begin_al = ctrl_i.trigger_alignment_select;
  assign cnt = trace_line_counter_o;
  // Begin alignment still waiting for the final state with nothing stored.
  sequence s_wait_final;
    (begin_al && !final_i && cnt == 7'h00 && !session_done_o) [*8];
  endsequence
  // Source disabled long enough that no capture is still in flight.
  sequence s_no_source;
    (!ctrl_i.trace_source_enable) [*4];
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |-> cnt == 7'h00 && !armed_o
    && !break_req_o && !session_done_o) else $error("outputs active in reset");
  cnt_sat_a: assert property (cnt <= 7'h40) else $error("counter above 64");
  cnt_step_a: assert property (cnt != $past(cnt) |-> cnt == $past(cnt) + 7'h01
    || cnt == 7'h00) else $error("counter jumped");
  no_source_a: assert property (s_no_source |-> cnt <= $past(cnt))
    else $error("line stored with source off");
  begin_wait_a: assert property (s_wait_final |=> cnt == 7'h00)
    else $error("line stored before final");
  brk_pulse_a: assert property ($rose(break_req_o) |=> !break_req_o)
    else $error("break request too long");
  brk_done_a: assert property (break_req_o |-> ##[0:2] session_done_o)
    else $error("break before session end");
  done_full_a: assert property ($rose(session_done_o) && begin_al |-> ##[0:3] cnt == 7'h40)
    else $error("session ended short of 64");
  end_disarm_a: assert property (!begin_al && final_i && armed_o |-> ##[1:3] !armed_o)
    else $error("still armed after final");
endmodule

bind dtb_store dtb_store_properties dtb_store_properties_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .ctrl_i(ctrl_i),
  .final_i(final_i),
  .trace_line_counter_o(trace_line_counter_o),
  .armed_o(armed_o),
  .session_done_o(session_done_o),
  .break_req_o(break_req_o)
);

/* verif/tb_dtb_store.sv */
// Self-checking testbench of the trace store.
`timescale 1ns/100ps
module tb_dtb_store
  import dtb_pkg::*;
;
  logic clk_i = 1'b1;
  logic rst_i = 1'b0;
  dtb_ctrl_type ctrl = '0;
  logic arm = 1'b0;
  logic fin = 1'b0;
  logic tag = 1'b0;
  logic [5:0] rd_index = 6'h00;
  dtb_exec_type exec;
  dtb_bus_type bus;
  logic [LINE_W-1:0] rd_line;
  logic [6:0] cnt;
  logic armed, done, brk, stall;
  int n_fail = 0;
  int cmp_count = 0;
  int brk_n = 0;
  int b0;
  // Free-running 125 MHz clock.
  always #4 clk_i = ~clk_i;
  // Counts break request pulses.
  always @(posedge clk_i) if (brk === 1'b1) brk_n <= brk_n + 1;
  dtb_store dtb_store_inst (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl), .arm_i(arm),
    .final_i(fin), .tagged_i(tag), .exec_i(exec), .bus_i(bus), .rd_index_i(rd_index),
    .rd_line_o(rd_line), .trace_line_counter_o(cnt), .armed_o(armed),
    .session_done_o(done), .break_req_o(brk), .stall_o(stall));
  dtb_core_model dtb_core_model_inst (.clk_i(clk_i), .stall_i(stall), .exec_o(exec),
    .bus_o(bus));
  // Compares one value and reports a difference.
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Resets, sets the controls, then arms the store.
  task automatic restart(input dtb_mode_type m, input logic al, input logic en);
    @(negedge clk_i);
    rst_i = 1'b1;
    arm = 1'b0;
    fin = 1'b0;
    tag = 1'b0;
    ctrl = '{trace_source_enable: en, trigger_alignment_select: al, trace_mode_select: m};
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    arm = 1'b1;
    @(negedge clk_i);
  endtask
  // Short forms of the core model's requests.
  task automatic op(input dtb_cof_type k, input logic [17:0] a);
    dtb_core_model_inst.run_op(k, a);
  endtask
  task automatic bus_op(input logic [3:0] k, input logic [17:0] a, input logic [15:0] d);
    dtb_core_model_inst.run_bus(k, a, d);
  endtask
  // Lets the FIFO, RAM and counter catch up.
  task automatic settle;
    repeat (4) @(negedge clk_i);
  endtask
  // Reads one trace line and compares it.
  task automatic rd(input logic [5:0] i, input logic [19:0] exp);
    rd_index = i;
    #1;
    check("trace line", rd_line, exp);
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    // Reset rises on the first falling edge so the design sees a reset edge.
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    // Source disabled: nothing is stored in any mode.
    for (int m = 0; m < 4; m++) begin
      restart(dtb_mode_type'(m), 1'b0, 1'b0);
      op(COF_COND_SRC, 18'h00100);
      bus_op(4'h1, 18'h00200, 16'h1234);
      settle();
      check("counter", cnt, 20'h0);
    end
    // Normal mode: every change-of-flow kind, only listed ones kept.
    restart(MODE_NORMAL, 1'b0, 1'b1);
    for (int k = 0; k < 8; k++) op(dtb_cof_type'(k), 18'h20000 + 18'(k));
    settle();
    check("counter", cnt, 20'h4);
    rd(0, {2'b00, 18'h20001});
    rd(1, {2'b10, 18'h20002});
    rd(2, {2'b10, 18'h20004});
    rd(3, {2'b11, 18'h20005});
    // Loop1 mode: only a repeated source is dropped.
    restart(MODE_LOOP1, 1'b0, 1'b1);
    op(COF_COND_SRC, 18'h01230);
    op(COF_COND_SRC, 18'h01230);
    op(COF_INDEXED_DST, 18'h2abcd);
    op(COF_INDEXED_DST, 18'h2abcd);
    op(COF_COND_SRC, 18'h01230);
    op(COF_VECTOR, 18'h0fff2);
    op(COF_VECTOR, 18'h0fff2);
    settle();
    check("counter", cnt, 20'h6);
    rd(2, {2'b10, 18'h2abcd});
    rd(3, {2'b00, 18'h01230});
    rd(5, {2'b11, 18'h0fff2});
    // Detail mode: free and fetch cycles skipped, two lines per access.
    restart(MODE_DETAIL, 1'b0, 1'b1);
    bus_op(4'h8, 18'h00010, 16'h1111);
    bus_op(4'h4, 18'h00020, 16'h2222);
    bus_op(4'h3, 18'h30abc, 16'h55a7);
    check("stall", stall, 20'h1);
    bus_op(4'h0, 18'h01002, 16'hbeef);
    settle();
    check("counter", cnt, 20'h4);
    rd(0, {SZ_BYTE, DIR_READ, 18'h30abc});
    rd(1, 20'h000a7);
    rd(2, {SZ_WORD, DIR_WRITE, 18'h01002});
    rd(3, 20'h0beef);
    // End alignment: wrap over the oldest line, then disarm at final.
    restart(MODE_NORMAL, 1'b0, 1'b1);
    for (int i = 0; i < 65; i++) op(COF_COND_SRC, 18'(i));
    settle();
    check("counter", cnt, 20'h40);
    rd(0, 20'h00040);
    rd(1, 20'h00001);
    fin = 1'b1;
    settle();
    check("armed", armed, 20'h0);
    op(COF_COND_SRC, 18'h3ffff);
    settle();
    rd(1, 20'h00001);
    // Begin alignment with a tag: wait for final, then 64 lines and a break.
    restart(MODE_NORMAL, 1'b1, 1'b1);
    tag = 1'b1;
    op(COF_COND_SRC, 18'h00777);
    settle();
    check("counter", cnt, 20'h0);
    b0 = brk_n;
    fin = 1'b1;
    for (int i = 0; i < 64; i++) begin
      op(COF_RETURN_DST, 18'h10000 + 18'(i));
      if (i == 31) check("armed", armed, 20'h1);
    end
    for (int w = 0; w < 20 && done !== 1'b1; w++) @(negedge clk_i);
    check("done", done, 20'h1);
    check("counter", cnt, 20'h40);
    @(negedge clk_i);
    check("breaks", 20'(brk_n - b0), 20'h1);
    rd(0, {2'b10, 18'h10000});
    rd(63, {2'b10, 18'h1003f});
    // Compressed mode: bases, increments oldest lowest, no opcode lost at a flush.
    restart(MODE_COMPRESSED, 1'b0, 1'b1);
    op(COF_NONE, 18'h04000);
    op(COF_NONE, 18'h04001);
    for (int i = 0; i < 5; i++) op(COF_NONE, 18'h08000 + 18'(i));
    op(COF_NONE, 18'h08040);
    settle();
    check("counter", cnt, 20'h6);
    rd(0, {INF_BASE, 18'h04000});
    rd(1, {INF_ONE, 18'h00001});
    rd(2, {INF_BASE, 18'h08000});
    rd(3, {INF_THREE, 18'h03081});
    rd(4, {INF_ONE, 18'h00004});
    rd(5, {INF_BASE, 18'h08040});
    stop_test();
  end
endmodule
